// ===== include/bsc_pkg.sv
package bsc_pkg;

  // ****************************************************************
  // Bus setup register fields and reset value
  // ****************************************************************
  localparam int        SHIFT_BIT    = 0;
  localparam int        ACK_LSB      = 1;
  localparam int        ACK_MSB      = 2;
  localparam int        SWAP_SEL_BIT = 6;
  localparam int        SWAP_EN_BIT  = 7;
  localparam logic [7:0] SETUP_RESET = 8'h00;

  // ****************************************************************
  // Interrupt acknowledge types and DMA channel codes
  // ****************************************************************
  localparam logic [1:0] ACK_STATUS = 2'h0;
  localparam logic [1:0] ACK_SINGLE = 2'h1;
  localparam logic [1:0] ACK_DOUBLE = 2'h3;
  localparam logic [1:0] CH_RX_A    = 2'h3;
  localparam logic [1:0] CH_TX_A    = 2'h2;
  localparam logic [1:0] CH_RX_B    = 2'h1;
  localparam logic [1:0] CH_TX_B    = 2'h0;

  // ****************************************************************
  // Synchroniser bit positions of the sampled pins
  // ****************************************************************
  localparam int SY_AS_B   = 0;
  localparam int SY_CE_B   = 1;
  localparam int SY_WR_B   = 2;
  localparam int SY_RD_B   = 3;
  localparam int SY_DS_B   = 4;
  localparam int SY_RW     = 5;
  localparam int SY_SECT   = 6;
  localparam int SY_CHAN   = 7;
  localparam int SY_ACK_B  = 8;
  localparam int SY_GRANT  = 9;
  localparam int SY_WRDY   = 10;
  localparam int SY_AD_LSB = 11;
  localparam int SY_WIDTH  = 27;

  // ****************************************************************
  // DMA bus master sequence
  // ****************************************************************
  typedef enum logic [2:0] {
    BSC_IDLE,
    BSC_REQ,
    BSC_ADR_LO,
    BSC_ADR_HI,
    BSC_DATA,
    BSC_DONE
  } bsc_state_e;

endpackage : bsc_pkg

// ===== logic/bsc_sync.sv
`timescale 1ns/1ps
module bsc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] init_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // Reset loads the idle level so no false edge appears on release.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      meta_ff  <= init_in;
      sync_out <= init_in;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : bsc_sync

// ===== logic/bsc_bus_setup.sv
// What this block does
// RL1 - Host's first access after reset writes setup
// RL2 - Only the first write loads setup register
// RL3 - Host holds section select low during setup
// RL4 - Strobe seen before setup selects multiplexed bus
// RL5 - Channel select high gives wait, low ready
// RL6 - Wait/ready choice governs pin both directions
// RL7 - Bit 0 picks DMA address shift, multiplexed
// RL8 - Bits 2:1 select interrupt acknowledge type
// RL9 - Status acknowledge latched on mode's strobe edge
// RL10 - Host holds status acknowledge whole cycle
// RL11 - Host writes zeros to bits 3-5
// RL12 - Bit 7 clear: DMA bytes from lower lane
// RL13 - Bit 6 chooses lane for even/odd addresses
// RL14 - Swapping only for bytes read as master
// RL15 - Select pins carry channel code during DMA
// RL16 - Master drives selects, strobes, address strobe
// RL17 - Request bus, start only after grant
// RL18 - Output 32-bit address with two strobes
// RL19 - Ready mode acknowledges transfers and vectors
// RL20 - External logic may abort on channel code
// RL21 - Double pulse: vector on second pulse only
// RL22 - Pulsed acknowledge strobes vector; status uses strobe
// RL23 - Configured flag set once, cleared by reset
`timescale 1ns/1ps
module bsc_bus_setup (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        addr_strobe_pin_b_in,
  input  wire logic        chip_enable_b_in,
  input  wire logic        write_strobe_b_in,
  input  wire logic        read_strobe_b_in,
  input  wire logic        data_strobe_pin_b_in,
  input  wire logic        read_not_write_in,
  input  wire logic        section_select_pin_in,
  input  wire logic        channel_select_pin_in,
  input  wire logic        irq_ack_input_b_in,
  input  wire logic        bus_grant_in,
  input  wire logic        wait_rdy_in,
  input  wire logic [15:0] ad_in,
  input  wire logic [7:0]  vector_in,
  input  wire logic        dma_start_in,
  input  wire logic        dma_to_memory_in,
  input  wire logic [31:0] dma_addr_in,
  input  wire logic [1:0]  dma_channel_in,
  input  wire logic [7:0]  dma_wdata_in,
  output logic             configured_out,
  output logic             mux_mode_out,
  output logic             wait_mode_out,
  output logic [7:0]       bus_setup_register_out,
  output logic [1:0]       ack_type_out,
  output logic [4:0]       dma_reg_addr_out,
  output logic             bus_request_out,
  output logic [15:0]      ad_out,
  output logic             ad_oe_b_out,
  output logic             addr_strobe_pin_b_out,
  output logic             upper_addr_strobe_b_out,
  output logic             read_strobe_b_out,
  output logic             write_strobe_b_out,
  output logic             data_strobe_pin_b_out,
  output logic             read_not_write_out,
  output logic             section_select_pin_out,
  output logic             channel_select_pin_out,
  output logic             master_oe_b_out,
  output logic             wait_rdy_out,
  output logic             wait_rdy_oe_b_out,
  output logic [7:0]       dma_rdata_out,
  output logic             dma_done_out
);
  import bsc_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SY_WIDTH-1:0] pin_s;
  logic [SY_WIDTH-1:0] pin_init;
  logic [SY_WIDTH-1:0] pin_prev_ff;

  assign pin_init = {16'h0000, 11'h13F};

  bsc_sync #(
    .W (SY_WIDTH)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   ({ad_in, wait_rdy_in, bus_grant_in, irq_ack_input_b_in,
                  channel_select_pin_in, section_select_pin_in,
                  read_not_write_in, data_strobe_pin_b_in,
                  read_strobe_b_in, write_strobe_b_in,
                  chip_enable_b_in, addr_strobe_pin_b_in}),
    .init_in    (pin_init),
    .sync_out   (pin_s)
  );

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      pin_prev_ff <= {16'h0000, 11'h13F};
    else
      pin_prev_ff <= pin_s;
  end

  logic [15:0] ad_s;
  logic        master;
  logic        wr_act;
  logic        wr_prev;
  logic        rd_act;
  logic        rd_prev;
  logic        as_fall;
  logic        as_rise;
  logic        ack_act;
  logic        ack_fall;
  logic        setup_write;

  assign ad_s    = pin_s[SY_AD_LSB +: 16];
  assign wr_act  = !pin_s[SY_WR_B] ||
                   (!pin_s[SY_DS_B] && !pin_s[SY_RW]);
  assign wr_prev = !pin_prev_ff[SY_WR_B] ||
                   (!pin_prev_ff[SY_DS_B] && !pin_prev_ff[SY_RW]);
  assign rd_act  = !pin_s[SY_RD_B] ||
                   (!pin_s[SY_DS_B] && pin_s[SY_RW]);
  assign rd_prev = !pin_prev_ff[SY_RD_B] ||
                   (!pin_prev_ff[SY_DS_B] && pin_prev_ff[SY_RW]);
  assign as_fall = !pin_s[SY_AS_B] && pin_prev_ff[SY_AS_B];
  assign as_rise = pin_s[SY_AS_B] && !pin_prev_ff[SY_AS_B];
  assign ack_act = !pin_s[SY_ACK_B];
  assign ack_fall = ack_act && pin_prev_ff[SY_ACK_B];

  // ****************************************************************
  // One-time bus setup capture
  // ****************************************************************
  logic       configured_ff;
  logic       as_seen_ff;
  logic       mux_mode_ff;
  logic       wait_mode_ff;
  logic [7:0] setup_ff;

  // The setup write is the first write strobe with chip enable low; the
  // host keeps the section select low then, so it is not decoded here.
  assign setup_write = !configured_ff && !master && wr_act && !wr_prev &&
                       !pin_s[SY_CE_B]; // RL2

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      configured_ff <= 1'b0;
      as_seen_ff    <= 1'b0;
      mux_mode_ff   <= 1'b0;
      wait_mode_ff  <= 1'b0;
      setup_ff      <= SETUP_RESET;
    end
    else if (setup_write)
    begin
      configured_ff <= 1'b1; // RL23
      mux_mode_ff   <= as_seen_ff || as_fall; // RL4
      wait_mode_ff  <= pin_s[SY_CHAN]; // RL5
      setup_ff      <= ad_s[7:0]; // RL2
    end
    else if (!configured_ff && as_fall)
    begin
      // Chip enable is deliberately ignored for this detection.
      as_seen_ff <= 1'b1; // RL4
    end
  end

  logic [1:0] ack_type;
  logic       swap_en;
  logic       swap_sel;

  assign ack_type = setup_ff[ACK_MSB:ACK_LSB]; // RL8
  assign swap_en  = setup_ff[SWAP_EN_BIT];
  assign swap_sel = setup_ff[SWAP_SEL_BIT];

  assign configured_out         = configured_ff;
  assign mux_mode_out           = mux_mode_ff;
  assign wait_mode_out          = wait_mode_ff;
  assign bus_setup_register_out = setup_ff;
  assign ack_type_out           = ack_type;

  // ****************************************************************
  // DMA-section register address decode
  // ****************************************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      dma_reg_addr_out <= 5'h00;
    else if (configured_ff && mux_mode_ff && !master && as_rise)
      dma_reg_addr_out <= setup_ff[SHIFT_BIT] ? ad_s[4:0] : ad_s[5:1]; // RL7
  end

  // ****************************************************************
  // Interrupt acknowledge and vector drive
  // ****************************************************************
  logic status_ack_ff;
  logic first_pulse_ff;
  logic second_ff;
  logic vector_drive;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      status_ack_ff <= 1'b0;
    else if (mux_mode_ff && as_rise)
      status_ack_ff <= ack_act; // RL9
    else if (!mux_mode_ff && rd_act && !rd_prev)
      status_ack_ff <= ack_act; // RL9
  end

  // The first pulse of a double acknowledge is only remembered.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      first_pulse_ff <= 1'b0;
      second_ff      <= 1'b0;
    end
    else if (ack_type != ACK_DOUBLE)
    begin
      first_pulse_ff <= 1'b0;
      second_ff      <= 1'b0;
    end
    else if (ack_fall)
    begin
      first_pulse_ff <= !first_pulse_ff; // RL21
      second_ff      <= first_pulse_ff; // RL21
    end
    else if (!ack_act)
    begin
      second_ff <= 1'b0;
    end
  end

  always_comb
  begin
    vector_drive = 1'b0;
    if (configured_ff && !master)
    begin
      unique case (ack_type)
        ACK_STATUS: vector_drive = status_ack_ff && rd_act; // RL22
        ACK_SINGLE: vector_drive = ack_act; // RL22
        ACK_DOUBLE: vector_drive = ack_act && second_ff; // RL21
        default:    vector_drive = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Wait/ready pin as slave
  // ****************************************************************
  logic slave_cycle;

  // In wait mode data is always on time, so the pin only reports ready.
  assign slave_cycle = !master && (vector_drive ||
                       (!pin_s[SY_CE_B] && (rd_act || wr_act)));
  assign wait_rdy_out      = wait_mode_ff; // RL6
  assign wait_rdy_oe_b_out = !slave_cycle; // RL19

  // ****************************************************************
  // DMA bus master sequence
  // ****************************************************************
  bsc_state_e state_ff;
  bsc_state_e nxt_state;
  logic       xfer_ok;

  // Wait mode stalls while the pin is low; ready mode ends on low.
  assign xfer_ok = wait_mode_ff ? pin_s[SY_WRDY] : !pin_s[SY_WRDY]; // RL6
  assign master  = (state_ff != BSC_IDLE) && (state_ff != BSC_REQ);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      // A grant left from the last transfer still sits in the synchroniser;
      // waiting for it to clear keeps a new request off a stale grant.
      BSC_IDLE:
        if (dma_start_in && configured_ff && !pin_s[SY_GRANT])
          nxt_state = BSC_REQ; // RL17
      BSC_REQ:
        if (pin_s[SY_GRANT])
          nxt_state = BSC_ADR_LO; // RL17
      BSC_ADR_LO:
        nxt_state = BSC_ADR_HI;
      BSC_ADR_HI:
        nxt_state = BSC_DATA;
      BSC_DATA:
        if (xfer_ok)
          nxt_state = BSC_DONE;
      BSC_DONE:
        nxt_state = BSC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      state_ff <= BSC_IDLE;
    else
      state_ff <= nxt_state;
  end

  assign bus_request_out = (state_ff != BSC_IDLE) &&
                           (state_ff != BSC_DONE); // RL17

  // ****************************************************************
  // Master pin drive
  // ****************************************************************
  logic [31:0] addr_ff;
  logic        to_mem_ff;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      addr_ff                 <= 32'h0000_0000;
      to_mem_ff               <= 1'b0;
      section_select_pin_out  <= 1'b0;
      channel_select_pin_out  <= 1'b0;
      master_oe_b_out         <= 1'b1;
      addr_strobe_pin_b_out   <= 1'b1;
      upper_addr_strobe_b_out <= 1'b1;
      read_strobe_b_out       <= 1'b1;
      write_strobe_b_out      <= 1'b1;
      data_strobe_pin_b_out   <= 1'b1;
      read_not_write_out      <= 1'b1;
    end
    else
    begin
      if (state_ff == BSC_IDLE)
      begin
        addr_ff                <= dma_addr_in;
        to_mem_ff              <= dma_to_memory_in;
        channel_select_pin_out <= dma_channel_in[1]; // RL15
        section_select_pin_out <= dma_channel_in[0]; // RL15
      end
      master_oe_b_out <= !((nxt_state != BSC_IDLE) &&
                           (nxt_state != BSC_REQ)); // RL16
      addr_strobe_pin_b_out   <= (nxt_state != BSC_ADR_LO); // RL18
      upper_addr_strobe_b_out <= (nxt_state != BSC_ADR_HI); // RL18
      read_strobe_b_out  <= !((nxt_state == BSC_DATA) && !to_mem_ff);
      write_strobe_b_out <= !((nxt_state == BSC_DATA) && to_mem_ff);
      data_strobe_pin_b_out <= (nxt_state != BSC_DATA);
      read_not_write_out    <= !to_mem_ff;
    end
  end

  // ****************************************************************
  // Address/data bus drive and byte acceptance
  // ****************************************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      ad_out      <= 16'h0000;
      ad_oe_b_out <= 1'b1;
    end
    else
    begin
      unique case (nxt_state)
        BSC_ADR_LO:
        begin
          ad_out      <= addr_ff[15:0]; // RL18
          ad_oe_b_out <= 1'b0;
        end
        BSC_ADR_HI:
        begin
          ad_out      <= addr_ff[31:16]; // RL18
          ad_oe_b_out <= 1'b0;
        end
        BSC_DATA:
        begin
          // Outgoing bytes are replicated and never swapped.
          ad_out      <= {dma_wdata_in, dma_wdata_in}; // RL14
          ad_oe_b_out <= !to_mem_ff;
        end
        default:
        begin
          ad_out      <= {vector_in, vector_in};
          ad_oe_b_out <= !vector_drive; // RL22
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      dma_rdata_out <= 8'h00;
      dma_done_out  <= 1'b0;
    end
    else
    begin
      dma_done_out <= (state_ff == BSC_DATA) && xfer_ok;
      if ((state_ff == BSC_DATA) && xfer_ok && !to_mem_ff) // RL14
      begin
        if (swap_en && (swap_sel == addr_ff[0])) // RL13
          dma_rdata_out <= ad_s[15:8];
        else
          dma_rdata_out <= ad_s[7:0]; // RL12
      end
    end
  end

endmodule : bsc_bus_setup

// ===== sim/bsc_mem_partner.sv
`timescale 1ns/1ps
module bsc_mem_partner (
  input  wire logic        sys_clk_in,
  input  wire logic        bus_request_in,
  input  wire logic        master_oe_b_in,
  input  wire logic        data_strobe_b_in,
  input  wire logic        wait_mode_in,
  input  wire logic [3:0]  delay_in,
  input  wire logic [15:0] mem_word_in,
  output logic             bus_grant_out,
  output logic             wait_rdy_out,
  output logic [15:0]      ad_out
);
  // ********
  // Arbiter and slow memory
  // ********
  logic [3:0] cnt   = 4'h0;
  logic       grant = 1'b0;
  logic       sel;
  logic       ok;

  always @(posedge sys_clk_in)
  begin
    // Aborting on the channel code is optional; this arbiter never aborts.
    grant <= bus_request_in;
    if (!sel)
      cnt <= 4'h0;
    else if (cnt != delay_in)
      cnt <= cnt + 4'h1;
  end

  assign bus_grant_out = grant;
  assign sel = !master_oe_b_in && !data_strobe_b_in;
  assign ok = sel && cnt == delay_in;
  // The not-ready level is the opposite one for each mode.
  assign wait_rdy_out = ok ? wait_mode_in : !wait_mode_in;
  // A released bus shows a changed pattern, never the old word.
  assign ad_out = sel ? mem_word_in : ~mem_word_in;
endmodule : bsc_mem_partner

// ===== sim/bsc_bus_setup_properties.sv
`timescale 1ns/1ps
module bsc_bus_setup_properties (
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        bus_grant_in,
  input wire logic [31:0] dma_addr_in,
  input wire logic [1:0]  dma_channel_in,
  input wire logic        configured_out,
  input wire logic        mux_mode_out,
  input wire logic        wait_mode_out,
  input wire logic [7:0]  bus_setup_register_out,
  input wire logic [1:0]  ack_type_out,
  input wire logic        bus_request_out,
  input wire logic [15:0] ad_out,
  input wire logic        addr_strobe_pin_b_out,
  input wire logic        upper_addr_strobe_b_out,
  input wire logic        section_select_pin_out,
  input wire logic        channel_select_pin_out,
  input wire logic        master_oe_b_out,
  input wire logic        wait_rdy_out,
  input wire logic        wait_rdy_oe_b_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  // ********
  // Address phases as bus master
  // ********
  sequence s_adr_lo;
    !master_oe_b_out && $fell(addr_strobe_pin_b_out);
  endsequence
  sequence s_adr_hi;
    !upper_addr_strobe_b_out && ad_out == dma_addr_in[31:16];
  endsequence

  AST_CONFIG_ONCE: assert property (
    configured_out |=> configured_out)
    else $error("configured flag dropped without reset");
  AST_SETUP_FROZEN: assert property (
    configured_out |=> $stable(bus_setup_register_out)
      && $stable(mux_mode_out) && $stable(wait_mode_out))
    else $error("bus setup changed after first write");
  AST_ACK_TYPE: assert property (
    configured_out |-> ack_type_out == bus_setup_register_out[2:1])
    else $error("ack type differs from setup bits 2:1");
  AST_WAIT_LEVEL: assert property (
    !wait_rdy_oe_b_out |-> master_oe_b_out && wait_rdy_out == wait_mode_out)
    else $error("wait/ready output level wrong for mode");
  AST_REQ_CONFIG: assert property (
    bus_request_out |-> configured_out)
    else $error("bus request before setup");
  AST_GRANT_FIRST: assert property (
    $fell(master_oe_b_out) |-> bus_grant_in && bus_request_out)
    else $error("bus taken without grant");
  AST_CHAN_CODE: assert property (
    !master_oe_b_out |->
      {channel_select_pin_out, section_select_pin_out} == dma_channel_in)
    else $error("channel code wrong on select pins");
  AST_ADDR_PHASES: assert property (
    s_adr_lo |-> ad_out == dma_addr_in[15:0] ##1 s_adr_hi)
    else $error("address phases out of order");
endmodule : bsc_bus_setup_properties

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bsc_pkg::*;
  // ********
  // Signals, design and partner
  // ********
  logic        sys_clk_in = 1'b0;
  logic        rst_b_in, addr_strobe_pin_b_in, chip_enable_b_in;
  logic        write_strobe_b_in, read_strobe_b_in, data_strobe_pin_b_in;
  logic        read_not_write_in, section_select_pin_in;
  logic        channel_select_pin_in, irq_ack_input_b_in, bus_grant_in;
  logic        wait_rdy_in, dma_start_in, dma_to_memory_in, configured_out;
  logic        mux_mode_out, wait_mode_out, bus_request_out, ad_oe_b_out;
  logic        addr_strobe_pin_b_out, upper_addr_strobe_b_out;
  logic        read_strobe_b_out, write_strobe_b_out, data_strobe_pin_b_out;
  logic        read_not_write_out, section_select_pin_out;
  logic        channel_select_pin_out, master_oe_b_out, wait_rdy_out;
  logic        wait_rdy_oe_b_out, dma_done_out, host_wait_mode;
  logic [1:0]  dma_channel_in, ack_type_out;
  logic [3:0]  mem_delay;
  logic [4:0]  dma_reg_addr_out;
  logic [7:0]  vector_in, dma_wdata_in, bus_setup_register_out;
  logic [7:0]  dma_rdata_out;
  logic [15:0] ad_in, ad_out, host_ad, mem_ad;
  logic [31:0] dma_addr_in;
  int          mismatches = 0;
  int          n_tests = 0;
  localparam logic [3:0]  CFG_AS    = 4'h6;
  localparam logic [3:0]  CFG_CH    = 4'hA;
  localparam logic [31:0] CFG_BYTES = 32'h420386C0;

  always #20 sys_clk_in = ~sys_clk_in;
  assign ad_in = (master_oe_b_out === 1'b0) ? mem_ad : host_ad;

  bsc_bus_setup i_bsc_bus_setup (
    .sys_clk_in, .rst_b_in, .addr_strobe_pin_b_in, .chip_enable_b_in,
    .write_strobe_b_in, .read_strobe_b_in, .data_strobe_pin_b_in,
    .read_not_write_in, .section_select_pin_in, .channel_select_pin_in,
    .irq_ack_input_b_in, .bus_grant_in, .wait_rdy_in, .ad_in, .vector_in,
    .dma_start_in, .dma_to_memory_in, .dma_addr_in, .dma_channel_in,
    .dma_wdata_in, .configured_out, .mux_mode_out, .wait_mode_out,
    .bus_setup_register_out, .ack_type_out, .dma_reg_addr_out,
    .bus_request_out, .ad_out, .ad_oe_b_out, .addr_strobe_pin_b_out,
    .upper_addr_strobe_b_out, .read_strobe_b_out, .write_strobe_b_out,
    .data_strobe_pin_b_out, .read_not_write_out, .section_select_pin_out,
    .channel_select_pin_out, .master_oe_b_out, .wait_rdy_out,
    .wait_rdy_oe_b_out, .dma_rdata_out, .dma_done_out);

  bsc_mem_partner i_bsc_mem_partner (
    .sys_clk_in, .bus_request_in(bus_request_out),
    .master_oe_b_in(master_oe_b_out), .data_strobe_b_in(data_strobe_pin_b_out),
    .wait_mode_in(host_wait_mode), .delay_in(mem_delay),
    .mem_word_in(16'hA55A), .bus_grant_out(bus_grant_in),
    .wait_rdy_out(wait_rdy_in), .ad_out(mem_ad));

  // ********
  // Host tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic host_write(input logic [7:0] d, input logic use_ds);
    @(negedge sys_clk_in);
    chip_enable_b_in = 1'b0;
    read_not_write_in = 1'b0;
    section_select_pin_in = 1'b0;
    host_ad = {8'h00, d};
    if (use_ds)
      data_strobe_pin_b_in = 1'b0;
    else
      write_strobe_b_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    {chip_enable_b_in, data_strobe_pin_b_in, write_strobe_b_in} = 3'h7;
    read_not_write_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
  endtask : host_write

  // Chip enable stays off: the strobe must count all the same.
  task automatic as_pulse(input logic [15:0] a);
    @(negedge sys_clk_in);
    host_ad = a;
    addr_strobe_pin_b_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    addr_strobe_pin_b_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
  endtask : as_pulse

  task automatic ack_pulse(input logic use_rd, output logic drove);
    drove = 1'b0;
    @(negedge sys_clk_in);
    irq_ack_input_b_in = 1'b0;
    repeat (8)
    begin
      @(negedge sys_clk_in);
      read_strobe_b_in = !use_rd;
      if (ad_oe_b_out === 1'b0 && ad_out[7:0] === vector_in
          && wait_rdy_oe_b_out === 1'b0)
        drove = 1'b1;
    end
    irq_ack_input_b_in = 1'b1;
    read_strobe_b_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
  endtask : ack_pulse

  task automatic dma_read(input logic [1:0] ch, input logic a0, wr,
                          input logic [7:0] exp);
    int   i;
    logic seen;
    i = 0;
    seen = 1'b0;
    @(negedge sys_clk_in);
    dma_channel_in = ch;
    dma_addr_in = {31'h091A2B3C, a0};
    dma_to_memory_in = wr;
    dma_start_in = 1'b1;
    // The start request stands until the bus request answers it.
    while (i < 60 && dma_done_out !== 1'b1)
    begin
      @(negedge sys_clk_in);
      i++;
      if (bus_request_out === 1'b1)
        dma_start_in = 1'b0;
      if (master_oe_b_out === 1'b0 && data_strobe_pin_b_out === 1'b0)
        seen = (read_not_write_out === !wr) && (wr ?
               (write_strobe_b_out === 1'b0 && ad_oe_b_out === 1'b0 &&
                ad_out === {2{dma_wdata_in}}) :
               (read_strobe_b_out === 1'b0 && ad_oe_b_out === 1'b1));
    end
    if (i == 60)
    begin
      mismatches++;
      end_sim();
    end
    check("dma_rdata_out", dma_rdata_out, exp);
    check("dma_strobes", seen, 1'b1);
  endtask : dma_read

  // ********
  // Main sequence: one reset and setup per configuration
  // ********
  initial
  begin
    logic       d1;
    logic       d2;
    logic [7:0] b;
    {addr_strobe_pin_b_in, chip_enable_b_in, write_strobe_b_in} = 3'h7;
    {read_strobe_b_in, data_strobe_pin_b_in, irq_ack_input_b_in} = 3'h7;
    {section_select_pin_in, channel_select_pin_in, dma_start_in} = 3'h0;
    read_not_write_in = 1'b1;
    dma_to_memory_in = 1'b0;
    dma_channel_in = 2'h0;
    dma_addr_in = 32'h0;
    dma_wdata_in = 8'h5A;
    vector_in = 8'h3C;
    host_ad = 16'h0000;
    host_wait_mode = 1'b0;
    mem_delay = 4'h0;
    for (int k = 0; k < 4; k++)
    begin
      b = CFG_BYTES[8*k +: 8];
      rst_b_in = 1'b0;
      repeat (3) @(negedge sys_clk_in);
      rst_b_in = 1'b1;
      check("configured_out", configured_out, 1'b0);
      check("setup_reg", bus_setup_register_out, SETUP_RESET);
      dma_start_in = 1'b1;
      repeat (8) @(negedge sys_clk_in);
      dma_start_in = 1'b0;
      check("bus_request_out", bus_request_out, 1'b0);
      if (CFG_AS[k])
        as_pulse(16'h0000);
      channel_select_pin_in = CFG_CH[k];
      host_wait_mode = CFG_CH[k];
      host_write(b, k[0]);
      check("mux_mode_out", mux_mode_out, CFG_AS[k]);
      check("wait_mode_out", wait_mode_out, CFG_CH[k]);
      check("setup_reg", bus_setup_register_out, b);
      check("ack_type_out", ack_type_out, b[2:1]);
      check("configured_out", configured_out, 1'b1);
      host_write(b ^ 8'hC7, !k[0]);
      check("setup_reg", bus_setup_register_out, b);
      if (CFG_AS[k])
      begin
        as_pulse(16'h002A);
        check("reg_addr", dma_reg_addr_out, b[0] ? 5'h0A : 5'h15);
      end
      mem_delay = 4'(3 * k);
      // The third transfer writes memory; the last read byte must stand.
      for (int a = 0; a < 3; a++)
        dma_read(k[1:0], a[0], a[1],
                 (b[7] && b[6] == (a != 0)) ? 8'hA5 : 8'h5A);
      ack_pulse(b[2:1] == ACK_STATUS, d1);
      ack_pulse(b[2:1] == ACK_STATUS, d2);
      check("vector_first", d1, b[2:1] != ACK_DOUBLE);
      check("vector_second", d2, 1'b1);
    end
    end_sim();
  end
endmodule : testbench

bind bsc_bus_setup bsc_bus_setup_properties i_props (
  .sys_clk_in, .rst_b_in, .bus_grant_in, .dma_addr_in, .dma_channel_in,
  .configured_out, .mux_mode_out, .wait_mode_out, .bus_setup_register_out,
  .ack_type_out, .bus_request_out, .ad_out, .addr_strobe_pin_b_out,
  .upper_addr_strobe_b_out, .section_select_pin_out,
  .channel_select_pin_out, .master_oe_b_out, .wait_rdy_out,
  .wait_rdy_oe_b_out);
